// ### mdl_error_monitor.v
// Error detection and reporting for one station of a polled multidrop network.
// Assumes a frame decoder on the same clock delivers one-cycle event pulses.
//
// Notes on behaviour
// - on error set station flag, store code
// - master records 01H on reply timeout
// - station mismatch: 02H master, 22H slave
// - counter mismatch: 03H master, 23H slave
// - malformed slave frame records 04H
// - slave records 14H for bad master frame
// - slave records 11H when master stalls
// - slave records 21H for absent station
// - poll before parameters records 31H self
// - timeout setting 5 gives 50 ms
// - retry count defaults to three
// - pattern 1 exchanges 32 bits, 4 words
// - timeout 5..255, times 10 ms
// - retry 0..10, exhaustion raises error
// - station 0 master, 1..7 slave
//
// Local design decisions: the address map and the Avalon-MM slave port.
`include "mdl_defines.vh"

module mdl_error_monitor #(
    parameter TICK_CYC = `MDL_TICK_CYC
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Avalon-MM slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Link events from frame decoder
    input wire poll_sent,
    input wire [2:0] poll_target,
    input wire reply_ok,
    input wire reply_fmt_bad,
    input wire [2:0] frame_src,
    input wire stn_mismatch,
    input wire cnt_mismatch,
    input wire mst_fmt_bad,
    input wire slave_answered,
    input wire no_station,
    input wire params_rcvd,
    // Results
    output wire is_master,
    output wire retry_poll,
    output wire [6:0] refresh_bits,
    output wire [3:0] refresh_words,
    output wire irq
);

// ==========================================================
// Settings, status, error and internal state registers
reg [2:0] own_station_number_setting_r;
reg [2:0] slave_count_setting_r;
reg [1:0] refresh_pattern_setting_r;
reg [3:0] retry_count_setting_r;
reg [7:0] timeout_setting_r;
reg [7:0] irq_status_r;
reg [7:0] irq_mask_r;
reg [7:0] station_error_flags_r;
reg [7:0] station_error_code_regs_r [0:7];
reg params_ok_r;
reg [31:0] tick_r;
reg [7:0] units_r;
reg wait_r;
reg sl_wait_r;
reg [3:0] tries_r;
reg [2:0] tgt_r;
reg rd_done_r;

wire wr = avs_write && avs_byteenable[0];
wire [7:0] wd = avs_writedata[7:0];
wire tick = (tick_r == TICK_CYC - 1);

assign is_master = (own_station_number_setting_r == 3'h0);
assign irq = |(irq_status_r & irq_mask_r);
// Reads take one wait cycle so read data comes from a flop
assign avs_waitrequest = avs_read && !rd_done_r;

// Refresh size per pattern; seven bits so the largest pattern fits
assign refresh_bits = (refresh_pattern_setting_r == 2'h1) ? 7'd`MDL_P1_BITS :
                      (refresh_pattern_setting_r == 2'h2) ? 7'd`MDL_P2_BITS : 7'h00;
assign refresh_words = (refresh_pattern_setting_r == 2'h2) ? 4'd`MDL_P2_WORDS : 4'd`MDL_P1_WORDS;

// ==========================================================
// Error event selection: one report per cycle, most specific first
reg ev;
reg [2:0] ev_stn;
reg [7:0] ev_code;
always @*
begin
    ev = 1'b0;
    ev_stn = 3'h0;
    ev_code = 8'h00;
    if (is_master)
    begin
        if (wait_r && units_r == timeout_setting_r && tries_r >= retry_count_setting_r)
        begin
            ev = 1'b1;
            ev_stn = tgt_r;
            ev_code = `MDL_ERR_SLV_TMO;
        end
        else if (reply_fmt_bad)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_FMT_SLV;
        end
        else if (stn_mismatch)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_STN_M;
        end
        else if (cnt_mismatch)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_CNT_M;
        end
    end
    else
    begin
        if (poll_sent && poll_target == own_station_number_setting_r && !params_ok_r)
        begin
            ev = 1'b1;
            ev_stn = own_station_number_setting_r;
            ev_code = `MDL_ERR_NO_PARAM;
        end
        else if (mst_fmt_bad)
        begin
            ev = 1'b1;
            ev_stn = 3'h0;
            ev_code = `MDL_ERR_FMT_MST;
        end
        else if (sl_wait_r && units_r == timeout_setting_r)
        begin
            ev = 1'b1;
            ev_stn = 3'h0;
            ev_code = `MDL_ERR_MST_TMO;
        end
        else if (reply_fmt_bad)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_FMT_SLV;
        end
        else if (no_station)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_NO_SLV;
        end
        else if (stn_mismatch)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_STN_S;
        end
        else if (cnt_mismatch)
        begin
            ev = 1'b1;
            ev_stn = frame_src;
            ev_code = `MDL_ERR_CNT_S;
        end
    end
end

// Master asks for a repoll while retries remain
assign retry_poll = is_master && wait_r && units_r == timeout_setting_r
                    && tries_r < retry_count_setting_r;

// ==========================================================
// Timeout timebase: 10 ms units, counted only while a wait is open
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        tick_r <= 32'h0;
        units_r <= 8'h00;
    end
    else if (!(wait_r || sl_wait_r) || poll_sent || slave_answered || reply_ok)
    begin
        tick_r <= 32'h0;
        units_r <= 8'h00;
    end
    else if (units_r == timeout_setting_r)
    begin
        tick_r <= 32'h0;
        units_r <= 8'h00; // Expiry restarts the window for the next try
    end
    else if (tick)
    begin
        tick_r <= 32'h0;
        units_r <= units_r + 8'h01;
    end
    else
    begin
        tick_r <= tick_r + 32'h1;
    end
end

// ==========================================================
// Poll tracking for master and slave roles
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        wait_r <= 1'b0;
        sl_wait_r <= 1'b0;
        tries_r <= 4'h0;
        tgt_r <= 3'h0;
        params_ok_r <= 1'b0;
    end
    else
    begin
        if (params_rcvd)
            params_ok_r <= 1'b1;
        if (is_master)
        begin
            sl_wait_r <= 1'b0;
            if (poll_sent && !(wait_r && poll_target == tgt_r))
            begin
                wait_r <= 1'b1;
                tgt_r <= poll_target;
                tries_r <= 4'h0;
            end
            else if (reply_ok)
                wait_r <= 1'b0;
            else if (wait_r && units_r == timeout_setting_r)
            begin
                if (tries_r >= retry_count_setting_r)
                    wait_r <= 1'b0;
                else
                    tries_r <= tries_r + 4'h1;
            end
        end
        else
        begin
            wait_r <= 1'b0;
            // Slave watches for master's next request after any answer
            if (poll_sent)
                sl_wait_r <= 1'b0;
            else if (slave_answered)
                sl_wait_r <= 1'b1;
            else if (units_r == timeout_setting_r)
                sl_wait_r <= 1'b0;
        end
    end
end

// ==========================================================
// Register writes, flags and codes; hardware set beats software clear
integer i;
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        own_station_number_setting_r <= 3'h0;
        slave_count_setting_r <= `MDL_RST_SLAVES;
        refresh_pattern_setting_r <= `MDL_RST_PATTERN;
        retry_count_setting_r <= `MDL_RST_RETRY;
        timeout_setting_r <= `MDL_RST_TIMEOUT;
        irq_status_r <= 8'h00;
        irq_mask_r <= 8'h00;
        station_error_flags_r <= 8'h00;
        for (i = 0; i < 8; i = i + 1)
            station_error_code_regs_r[i] <= 8'h00;
    end
    else
    begin
        if (wr && avs_address == `MDL_ADDR_STATION)
            own_station_number_setting_r <= wd[2:0];
        if (wr && avs_address == `MDL_ADDR_SLAVES && wd[2:0] != 3'h0)
            slave_count_setting_r <= wd[2:0];
        if (wr && avs_address == `MDL_ADDR_PATTERN && wd[1:0] != 2'h3)
            refresh_pattern_setting_r <= wd[1:0];
        if (wr && avs_address == `MDL_ADDR_RETRY && wd[3:0] <= `MDL_RETRY_MAX)
            retry_count_setting_r <= wd[3:0];
        if (wr && avs_address == `MDL_ADDR_TIMEOUT && wd >= `MDL_TIMEOUT_MIN)
            timeout_setting_r <= wd;
        if (wr && avs_address == `MDL_ADDR_MASK)
            irq_mask_r <= wd;
        for (i = 0; i < 8; i = i + 1)
        begin
            if (ev && ev_stn == i)
            begin
                station_error_flags_r[i] <= 1'b1;
                irq_status_r[i] <= 1'b1;
                station_error_code_regs_r[i] <= ev_code;
            end
            else
            begin
                if (wr && avs_address == `MDL_ADDR_FLAGS && wd[i])
                    station_error_flags_r[i] <= 1'b0;
                if (wr && avs_address == `MDL_ADDR_STATUS && wd[i])
                    irq_status_r[i] <= 1'b0;
            end
        end
    end
end

// ==========================================================
// Read data, registered; unmapped addresses read zero
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        avs_readdata <= 32'h0;
        rd_done_r <= 1'b0;
    end
    else
    begin
        rd_done_r <= avs_read && !rd_done_r;
        avs_readdata <= 32'h0;
        if (avs_read)
        begin
            case (avs_address)
                `MDL_ADDR_STATION: avs_readdata <= {29'h0, own_station_number_setting_r};
                `MDL_ADDR_SLAVES: avs_readdata <= {29'h0, slave_count_setting_r};
                `MDL_ADDR_PATTERN: avs_readdata <= {30'h0, refresh_pattern_setting_r};
                `MDL_ADDR_RETRY: avs_readdata <= {28'h0, retry_count_setting_r};
                `MDL_ADDR_TIMEOUT: avs_readdata <= {24'h0, timeout_setting_r};
                `MDL_ADDR_STATUS: avs_readdata <= {24'h0, irq_status_r};
                `MDL_ADDR_MASK: avs_readdata <= {24'h0, irq_mask_r};
                `MDL_ADDR_FLAGS: avs_readdata <= {24'h0, station_error_flags_r};
                default:
                begin
                    if (avs_address >= `MDL_ADDR_CODE0 && avs_address <= `MDL_ADDR_CODE7
                        && avs_address[1:0] == 2'h0)
                        avs_readdata <= {24'h0, station_error_code_regs_r[avs_address[4:2]]};
                end
            endcase
        end
    end
end

endmodule

// ### mdl_defines.vh
// Constants for the multidrop link error monitor.
// Assumes a 250 MHz station clock and an Avalon-MM register port.
`ifndef MDL_DEFINES_VH
`define MDL_DEFINES_VH
// ==========================================================
// Register byte addresses
`define MDL_ADDR_STATION   8'h00
`define MDL_ADDR_SLAVES    8'h04
`define MDL_ADDR_PATTERN   8'h08
`define MDL_ADDR_RETRY     8'h0C
`define MDL_ADDR_TIMEOUT   8'h10
`define MDL_ADDR_STATUS    8'h14
`define MDL_ADDR_MASK      8'h18
`define MDL_ADDR_FLAGS     8'h1C
`define MDL_ADDR_CODE0     8'h20
`define MDL_ADDR_CODE7     8'h3C
// ==========================================================
// Reset values and write limits
`define MDL_RST_SLAVES     3'h7
`define MDL_RST_PATTERN    2'h0
`define MDL_RST_RETRY      4'h3
`define MDL_RST_TIMEOUT    8'h05
`define MDL_TIMEOUT_MIN    8'h05
`define MDL_RETRY_MAX      4'hA
// ==========================================================
// Error codes
`define MDL_ERR_SLV_TMO    8'h01
`define MDL_ERR_STN_M      8'h02
`define MDL_ERR_CNT_M      8'h03
`define MDL_ERR_FMT_SLV    8'h04
`define MDL_ERR_MST_TMO    8'h11
`define MDL_ERR_FMT_MST    8'h14
`define MDL_ERR_NO_SLV     8'h21
`define MDL_ERR_STN_S      8'h22
`define MDL_ERR_CNT_S      8'h23
`define MDL_ERR_NO_PARAM   8'h31
// ==========================================================
// Timing: one timeout unit is 10 ms
`define MDL_TICK_MS        10
`define MDL_CLK_MHZ        250
`define MDL_TICK_CYC       (`MDL_TICK_MS * 1000 * `MDL_CLK_MHZ)
// Refresh pattern sizes
`define MDL_P1_BITS        32
`define MDL_P1_WORDS       4
`define MDL_P2_BITS        64
`define MDL_P2_WORDS       8
`endif

// ### mdl_error_monitor_sva.sv
// Port checker for the link error monitor.
// Assumes it is bound to mdl_error_monitor with one clock.
// ==========
// Checker
module mdl_sva #(
    parameter TICK_CYC = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Link side
    input wire logic poll_sent,
    input wire logic reply_ok,
    input wire logic is_master,
    input wire logic retry_poll,
    input wire logic [6:0] refresh_bits,
    input wire logic [3:0] refresh_words,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic open_r;
    logic [15:0] wait_r;
    // Poll wait tracking; a retry restarts the count
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            open_r <= 1'b0;
            wait_r <= 16'h0000;
        end
        else
        begin
            open_r <= (poll_sent && is_master) | (open_r & ~reply_ok);
            wait_r <= (poll_sent | retry_poll | reply_ok) ? 16'h0000 : wait_r + 16'h0001;
        end
    end
    property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wait_src; avs_waitrequest |-> avs_read; endproperty
    a_wait_src: assert property (p_wait_src) else $error("stray wait");
    property p_refresh; refresh_words != 4'h8 |-> refresh_words == 4'h4 && refresh_bits[4:0] == 5'h00; endproperty
    a_refresh: assert property (p_refresh) else $error("pattern size wrong");
    property p_retry_master; retry_poll |-> is_master ##1 !retry_poll; endproperty
    a_retry_master: assert property (p_retry_master) else $error("bad retry pulse");
    property p_retry_open; retry_poll |-> open_r; endproperty
    a_retry_open: assert property (p_retry_open) else $error("retry without poll");
    property p_retry_late; retry_poll |-> wait_r >= 5 * TICK_CYC - 2; endproperty
    a_retry_late: assert property (p_retry_late) else $error("retry too early");
    property p_irq_fall; $fell(irq) |-> $past(avs_write); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    c_retry: cover property (retry_poll);
    c_irq: cover property (irq);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule

// ### mdl_far_station.sv
// Far-side station model: one bench command becomes one event pulse.
// Assumes the bench clock; answers come prompt or after a delay.
// ==========
// Station model
module mdl_far_station (
    // Clock
    input wire logic clk,
    // Command from the bench
    input wire logic go,
    input wire logic [3:0] kind,
    input wire logic [2:0] src,
    input wire logic [7:0] dly,
    // Event lines toward the monitor
    output logic [8:0] ev = 9'h000,
    output logic [2:0] tgt = 3'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] k_r = 4'h0;
    logic [2:0] s_r = 3'h0;
    logic [7:0] cnt_r = 8'h00;
    logic pend_r = 1'b0;
    // Idle station number shows the inverse, never a stale value
    always @(posedge clk)
    begin
        ev <= 9'h000;
        tgt <= ~s_r;
        if (go)
        begin
            k_r <= kind;
            s_r <= src;
            cnt_r <= dly; // Zero answers at once, more answers slowly
            pend_r <= 1'b1;
        end
        else if (pend_r && cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        else if (pend_r)
        begin
            ev <= 9'h001 << k_r;
            tgt <= s_r;
            pend_r <= 1'b0;
        end
    end
endmodule

// ### tb_top.sv
// Bench for the link error monitor: register tasks and event scenarios.
// Assumes the monitor, the station model and the checker.
`include "mdl_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam TICK = 4;
    localparam TMO = 5 * TICK;
    localparam logic [15:0] TBL [0:7] = '{16'h2104, 16'h3102, 16'h4103, 16'h5014, 16'h7321, 16'h3222, 16'h4223,
        16'h2404};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] av_a = 8'h00;
    logic av_r = 1'b0;
    logic av_w = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] rdata, rd;
    logic waitreq, is_master, retry_poll, irq, go = 1'b0;
    logic [3:0] kind = 4'h0;
    logic [2:0] src = 3'h0;
    logic [7:0] dly = 8'h00;
    logic [8:0] ev;
    logic [2:0] tgt;
    logic [6:0] rbits;
    logic [3:0] rwords;
    integer bad_count = 0, tests_run = 0, n_retry = 0, cyc = 0, i;
    // ==========
    // Clock, parts
    initial forever #2 clk = ~clk;
    mdl_error_monitor #(.TICK_CYC(TICK)) DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(av_a), .avs_read(av_r),
        .avs_write(av_w), .avs_writedata(av_wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .poll_sent(ev[0]), .poll_target(tgt), .reply_ok(ev[1]), .reply_fmt_bad(ev[2]),
        .frame_src(tgt), .stn_mismatch(ev[3]), .cnt_mismatch(ev[4]), .mst_fmt_bad(ev[5]), .slave_answered(ev[6]),
        .no_station(ev[7]), .params_rcvd(ev[8]), .is_master(is_master), .retry_poll(retry_poll),
        .refresh_bits(rbits), .refresh_words(rwords), .irq(irq));
    mdl_far_station FAR (.clk(clk), .go(go), .kind(kind), .src(src), .dly(dly), .ev(ev), .tgt(tgt));
    // ==========
    // Tasks
    task stop_test;
    begin
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Request held until waitrequest is seen low at an edge
    task xfer(input logic r, input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        av_a <= a;
        av_wd <= d;
        av_r <= r;
        av_w <= ~r;
        @(posedge clk);
        while (waitreq !== 1'b0)
            @(posedge clk);
        rd = rdata;
        av_r <= 1'b0;
        av_w <= 1'b0;
    end
    endtask
    task rc(input [7:0] a, input [31:0] exp);
    begin
        xfer(1'b1, a, 32'h0);
        chk(rd, exp);
    end
    endtask
    task evt(input [3:0] k, input [2:0] s, input [7:0] d);
    begin
        @(posedge clk);
        kind <= k;
        src <= s;
        dly <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (d + 3) @(posedge clk);
    end
    endtask
    task run_tbl(input integer lo, input integer hi);
    begin
        for (i = lo; i <= hi; i = i + 1)
        begin
            evt(TBL[i][15:12], TBL[i][10:8], 8'h00);
            rc(`MDL_ADDR_CODE0 + 4 * TBL[i][10:8], TBL[i][7:0]);
        end
    end
    endtask
    // Retry pulse count and hang guard; the run needs well under 2000 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (retry_poll === 1'b1)
            n_retry <= n_retry + 1;
        if (cyc == 6000)
        begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end
    // ==========
    // Scenarios
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rc(`MDL_ADDR_RETRY, 32'h3);
        rc(`MDL_ADDR_TIMEOUT, 32'h5);
        chk({is_master, rbits, rwords}, {1'b1, 7'h00, 4'h4});
        xfer(1'b0, `MDL_ADDR_PATTERN, 32'h2);
        xfer(1'b0, `MDL_ADDR_PATTERN, 32'h3);
        #1;
        chk({rbits, rwords}, {7'h40, 4'h8});
        xfer(1'b0, `MDL_ADDR_PATTERN, 32'h1);
        xfer(1'b0, `MDL_ADDR_SLAVES, 32'h2);
        xfer(1'b0, `MDL_ADDR_SLAVES, 32'h0);
        xfer(1'b0, `MDL_ADDR_RETRY, 32'hB);
        xfer(1'b0, `MDL_ADDR_TIMEOUT, 32'h4);
        rc(`MDL_ADDR_RETRY, 32'h3);
        rc(`MDL_ADDR_TIMEOUT, 32'h5);
        rc(`MDL_ADDR_SLAVES, 32'h2);
        rc(8'h80, 32'h0);
        chk({rbits, rwords}, {7'h20, 4'h4});
        xfer(1'b0, `MDL_ADDR_MASK, 32'h4);
        evt(4'h0, 3'h2, 8'h00);
        repeat (TMO) @(posedge clk);
        chk(n_retry, 0);
        repeat (4) @(posedge clk);
        chk(n_retry, 1);
        repeat (3 * TMO + 8) @(posedge clk);
        chk(n_retry, 3);
        rc(`MDL_ADDR_CODE0 + 8'h08, 32'h01);
        rc(`MDL_ADDR_FLAGS, 32'h4);
        chk(irq, 1);
        xfer(1'b0, `MDL_ADDR_STATUS, 32'h4);
        #1;
        chk(irq, 0);
        xfer(1'b0, `MDL_ADDR_RETRY, 32'h0);
        evt(4'h0, 3'h1, 8'h00);
        repeat (TMO + 8) @(posedge clk);
        chk(n_retry, 3);
        rc(`MDL_ADDR_CODE0 + 8'h04, 32'h01);
        xfer(1'b0, `MDL_ADDR_RETRY, 32'h3);
        evt(4'h0, 3'h3, 8'h00);
        evt(4'h1, 3'h3, 8'h05);
        repeat (2 * TMO) @(posedge clk);
        chk(n_retry, 3);
        rc(`MDL_ADDR_CODE0 + 8'h0C, 32'h0);
        run_tbl(0, 2);
        xfer(1'b0, `MDL_ADDR_STATION, 32'h1);
        #1;
        chk(is_master, 0);
        evt(4'h0, 3'h1, 8'h00);
        rc(`MDL_ADDR_CODE0 + 8'h04, 32'h31);
        evt(4'h8, 3'h0, 8'h00);
        run_tbl(3, 7);
        evt(4'h6, 3'h2, 8'h00);
        repeat (TMO + 8) @(posedge clk);
        rc(`MDL_ADDR_CODE0, 32'h11);
        stop_test;
    end
endmodule
bind mdl_error_monitor mdl_sva #(.TICK_CYC(TICK_CYC)) u_sva (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .poll_sent(poll_sent), .reply_ok(reply_ok),
    .is_master(is_master), .retry_poll(retry_poll), .refresh_bits(refresh_bits), .refresh_words(refresh_words),
    .irq(irq));
